/* File: design/vic_regs.svh */
// constants for the vectored interrupt controller: vector numbers, line map,
// priority field layout and table geometry.
// assumes: included by its bare name from the package and the top module.
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

// ----------------------------------------
// geometry
// ----------------------------------------
`define VIC_NUM_LINES 32
`define VIC_LINE_W 5
`define VIC_NUM_LEVELS 4
`define VIC_PRIO_W 2
`define VIC_LINES_PER_REG 4
`define VIC_NUM_PRIO_REGS 8
`define VIC_PRIO_FIELD_OFS 6
`define VIC_PRIO_BYTE_W 8
`define VIC_VEC_W 8
`define VIC_ADDR_W 32

// ----------------------------------------
// vector numbers and table
// ----------------------------------------
`define VIC_VEC_NONE 8'h00
`define VIC_VEC_NMI 8'h02
`define VIC_VEC_HARD_FAULT 8'h03
`define VIC_VEC_SUPERVISOR_CALL 8'h0B
`define VIC_VEC_PENDABLE_SERVICE 8'h0E
`define VIC_VEC_CORE_TICK 8'h0F
`define VIC_PERIPH_BASE 8'h10
`define VIC_TABLE_BASE 32'h0000_0000
`define VIC_ENTRY_SHIFT 2

// ----------------------------------------
// peripheral line assignment
// ----------------------------------------
`define VIC_LINE_DMA0 0
`define VIC_LINE_FLASH 5
`define VIC_LINE_POWER 6
`define VIC_LINE_WAKEUP 7
`define VIC_LINE_I2C0 8
`define VIC_LINE_SPI0 10
`define VIC_LINE_UART0 12
`define VIC_LINE_ADC 15
`define VIC_LINE_CMP 16
`define VIC_LINE_TIMER0 17
`define VIC_LINE_RTC_ALARM 20
`define VIC_LINE_RTC_SECONDS 21
`define VIC_LINE_PERIODIC 22
`define VIC_LINE_CLKGEN 27
`define VIC_LINE_LPTIMER 28
`define VIC_LINE_PORT_A 30
`define VIC_LINE_PORT_D 31
`define VIC_NUM_DMA 4
`define VIC_NUM_I2C 2
`define VIC_NUM_SPI 2
`define VIC_NUM_UART 3
`define VIC_NUM_TIMER 3
`define VIC_NUM_PERIODIC_CH 2

`endif

/* File: design/vic_pkg.sv */
// types for the vectored interrupt controller.
// assumes: vic_regs.svh on the include path.
`include "vic_regs.svh"

package vic_pkg;

	// ----------------------------------------
	// delivery state machine
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PRESENT = 3'b010,
		ST_ACTIVE = 3'b100
	} vic_state_e;

	// ----------------------------------------
	// peripheral request sources
	// ----------------------------------------
	typedef struct packed {
		logic [`VIC_NUM_DMA-1:0] dma_done_err;
		logic flash_cmd_done;
		logic flash_read_collision;
		logic power_low_volt_detect;
		logic power_low_volt_warn;
		logic wakeup;
		logic [`VIC_NUM_I2C-1:0] i2c;
		logic [`VIC_NUM_SPI-1:0] spi;
		logic [`VIC_NUM_UART-1:0] uart;
		logic analog_converter;
		logic comparator;
		logic [`VIC_NUM_TIMER-1:0] timer_modules;
		logic rtc_alarm;
		logic rtc_seconds;
		logic [`VIC_NUM_PERIODIC_CH-1:0] periodic_timer;
		logic clock_generator;
		logic low_power_timer;
		logic port_a_detect;
		logic port_d_detect;
	} periph_src_s;

	// ----------------------------------------
	// core exception requests
	// ----------------------------------------
	typedef struct packed {
		logic hard_fault;
		logic supervisor_call;
		logic pendable_service_request;
		logic core_tick_timer;
	} core_exc_s;

	typedef logic [`VIC_NUM_PRIO_REGS-1:0][31:0] prio_regs_t;
	typedef logic [`VIC_NUM_LINES-1:0][`VIC_PRIO_W-1:0] prio_fields_t;

endpackage : vic_pkg

/* File: design/vic_priority_arbiter.sv */
// priority arbiter: picks the pending line of most urgent level.
// assumes: purely combinational, fed from registered pending and fields.
`include "vic_regs.svh"

module vic_priority_arbiter
	import vic_pkg::*;
(
	input wire logic [`VIC_NUM_LINES-1:0] i_pending,
	input wire prio_fields_t i_fields,
	output logic o_found,
	output logic [`VIC_LINE_W-1:0] o_line,
	output logic [`VIC_PRIO_W-1:0] o_level
);

	// ----------------------------------------
	// level 0 is most urgent; lowest line wins a tie
	// ----------------------------------------
	always_comb begin
		o_found = 1'b0;
		o_line = '0;
		o_level = '0;
		for (int lvl = 0; lvl < `VIC_NUM_LEVELS; lvl++) begin // [RQ1]
			for (int i = 0; i < `VIC_NUM_LINES; i++) begin
				if (!o_found && i_pending[i] && i_fields[i] == lvl[`VIC_PRIO_W-1:0]) begin
					o_found = 1'b1;
					o_line = i[`VIC_LINE_W-1:0];
					o_level = lvl[`VIC_PRIO_W-1:0];
				end
			end
		end
	end

endmodule : vic_priority_arbiter

/* File: design/vectored_interrupt_controller.sv */
// vectored interrupt controller: maps sources to lines, arbitrates by
// priority and presents one vector at a time to the core.
// assumes: all inputs synchronous to i_clk; the core acknowledges a
// presented vector with i_ack and ends service with i_exc_return.
`include "vic_regs.svh"

// What this block does
// RQ1: exactly four priority levels arbitrate peripheral lines
// RQ2: each priority field is two bits wide
// RQ3: nmi request comes from active-low pin
// RQ4: software must mux pin to nmi function
// RQ5: serviced vector number is recorded for stacking
// RQ6: line index equals vector number minus sixteen
// RQ7: priority register chosen by line divided four
// RQ8: fixed core exception vectors 2,3,11,14,15
// RQ9: dma channels drive lines 0 to 3
// RQ10: flash shares line 5; line 4 empty
// RQ11: power line 6, wakeup unit line 7
// RQ12: i2c 8-9, spi 10-11, uart 12-14
// RQ13: rtc lines 20-21, periodic timer line 22
// RQ14: port a line 30, port d line 31
// RQ15: table entry at four times vector number
// RQ16: adc 15, cmp 16, timers 17-19, 27, 28
// RQ17: thirty-two peripheral request lines accepted
// RQ18: field at byte top, bit 8*(idx%4)+6
module vectored_interrupt_controller
	import vic_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_clk_en,
	input wire periph_src_s i_src,
	input wire core_exc_s i_core_exc,
	input wire logic i_nmi_pin_n,
	input wire logic i_nmi_pin_sel,
	input wire logic [`VIC_NUM_LINES-1:0] i_line_enable,
	input wire prio_regs_t i_priority_registers,
	input wire logic i_ack,
	input wire logic i_exc_return,
	output logic o_req,
	output logic [`VIC_VEC_W-1:0] o_vector,
	output logic [`VIC_ADDR_W-1:0] o_vector_addr,
	output logic [`VIC_VEC_W-1:0] o_stacked_vector,
	output logic [`VIC_PRIO_W-1:0] o_level,
	output logic [`VIC_NUM_LINES-1:0] o_pending
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	vic_state_e state_reg;
	vic_state_e state_next;
	logic [`VIC_NUM_LINES-1:0] lines;
	logic nmi_reg;
	prio_fields_t fields;
	logic arb_found;
	logic [`VIC_LINE_W-1:0] arb_line;
	logic [`VIC_PRIO_W-1:0] arb_level;
	logic [`VIC_VEC_W-1:0] vector_next;
	logic any_next;

	// ----------------------------------------
	// source to line map
	// ----------------------------------------
	// unused lines are tied low so they can never win arbitration
	always_comb begin
		lines = '0;
		lines[`VIC_LINE_DMA0 +: `VIC_NUM_DMA] = i_src.dma_done_err; // [RQ9]
		lines[`VIC_LINE_FLASH] = i_src.flash_cmd_done | i_src.flash_read_collision; // [RQ10]
		lines[`VIC_LINE_POWER] = i_src.power_low_volt_detect | i_src.power_low_volt_warn; // [RQ11]
		lines[`VIC_LINE_WAKEUP] = i_src.wakeup; // [RQ11]
		lines[`VIC_LINE_I2C0 +: `VIC_NUM_I2C] = i_src.i2c; // [RQ12]
		lines[`VIC_LINE_SPI0 +: `VIC_NUM_SPI] = i_src.spi; // [RQ12]
		lines[`VIC_LINE_UART0 +: `VIC_NUM_UART] = i_src.uart; // [RQ12]
		lines[`VIC_LINE_ADC] = i_src.analog_converter; // [RQ16]
		lines[`VIC_LINE_CMP] = i_src.comparator; // [RQ16]
		lines[`VIC_LINE_TIMER0 +: `VIC_NUM_TIMER] = i_src.timer_modules; // [RQ16]
		lines[`VIC_LINE_RTC_ALARM] = i_src.rtc_alarm; // [RQ13]
		lines[`VIC_LINE_RTC_SECONDS] = i_src.rtc_seconds; // [RQ13]
		lines[`VIC_LINE_PERIODIC] = |i_src.periodic_timer; // [RQ13]
		lines[`VIC_LINE_CLKGEN] = i_src.clock_generator; // [RQ16]
		lines[`VIC_LINE_LPTIMER] = i_src.low_power_timer; // [RQ16]
		lines[`VIC_LINE_PORT_A] = i_src.port_a_detect; // [RQ14]
		lines[`VIC_LINE_PORT_D] = i_src.port_d_detect; // [RQ14]
	end

	// ----------------------------------------
	// pending capture, all 32 lines gated by enable
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_pending <= '0;
		end else if (i_clk_en) begin
			o_pending <= lines & i_line_enable; // [RQ17]
		end
	end

	// ----------------------------------------
	// nmi from the low pin, only when muxed to that function
	// ----------------------------------------
	// no pin filter here: the pad logic is assumed to deglitch
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			nmi_reg <= 1'b0;
		end else if (i_clk_en) begin
			nmi_reg <= ~i_nmi_pin_n & i_nmi_pin_sel; // [RQ3] [RQ4]
		end
	end

	// ----------------------------------------
	// field extraction: register idx/4, offset 8*(idx%4)+6
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `VIC_NUM_LINES; g++) begin : g_field
			assign fields[g] = i_priority_registers[g / `VIC_LINES_PER_REG] // [RQ7]
				[`VIC_PRIO_BYTE_W * (g % `VIC_LINES_PER_REG) + `VIC_PRIO_FIELD_OFS +: `VIC_PRIO_W]; // [RQ18] [RQ2]
		end
	endgenerate

	vic_priority_arbiter u_arbiter (
		.i_pending(o_pending),
		.i_fields(fields),
		.o_found(arb_found),
		.o_line(arb_line),
		.o_level(arb_level)
	);

	// ----------------------------------------
	// vector selection: core exceptions ahead of peripherals
	// ----------------------------------------
	always_comb begin
		any_next = 1'b1;
		if (nmi_reg) begin
			vector_next = `VIC_VEC_NMI; // [RQ8]
		end else if (i_core_exc.hard_fault) begin
			vector_next = `VIC_VEC_HARD_FAULT; // [RQ8]
		end else if (i_core_exc.supervisor_call) begin
			vector_next = `VIC_VEC_SUPERVISOR_CALL; // [RQ8]
		end else if (i_core_exc.pendable_service_request) begin
			vector_next = `VIC_VEC_PENDABLE_SERVICE; // [RQ8]
		end else if (i_core_exc.core_tick_timer) begin
			vector_next = `VIC_VEC_CORE_TICK; // [RQ8]
		end else if (arb_found) begin
			vector_next = `VIC_PERIPH_BASE + {3'h0, arb_line}; // [RQ6]
		end else begin
			vector_next = `VIC_VEC_NONE;
			any_next = 1'b0;
		end
	end

	// ----------------------------------------
	// delivery state machine
	// ----------------------------------------
	// one exception at a time; nesting is left to the core
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (any_next) begin
					state_next = ST_PRESENT;
				end
			end
			ST_PRESENT: begin
				if (i_ack) begin
					state_next = ST_ACTIVE;
				end
			end
			ST_ACTIVE: begin
				if (i_exc_return) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_reg <= ST_IDLE;
		end else if (i_clk_en) begin
			state_reg <= state_next;
		end
	end

	// request line mirrors the presenting state, registered
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_req <= 1'b0;
		end else if (i_clk_en) begin
			o_req <= (state_next == ST_PRESENT);
		end
	end

	// ----------------------------------------
	// presented vector, level and table address
	// ----------------------------------------
	// vector is frozen while presented so the ack sees a stable value
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_vector <= `VIC_VEC_NONE;
			o_level <= '0;
			o_vector_addr <= `VIC_TABLE_BASE;
		end else if (i_clk_en && state_reg == ST_IDLE && any_next) begin
			o_vector <= vector_next;
			o_level <= arb_level;
			o_vector_addr <= `VIC_TABLE_BASE + ({24'h0, vector_next} << `VIC_ENTRY_SHIFT); // [RQ15]
		end
	end

	// ----------------------------------------
	// stacked vector number, taken on acknowledge
	// ----------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_stacked_vector <= `VIC_VEC_NONE;
		end else if (i_clk_en && state_reg == ST_PRESENT && i_ack) begin
			o_stacked_vector <= o_vector; // [RQ5]
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_nmi_from_pin: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ3]
		i_clk_en && !i_nmi_pin_n && i_nmi_pin_sel |=> nmi_reg)
		else $error("nmi pin low and selected did not raise request");

	a_nmi_needs_mux: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ4]
		i_clk_en && !i_nmi_pin_sel |=> !nmi_reg)
		else $error("nmi raised without pin function selected");

	a_stack_records_vec: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ5]
		i_clk_en && state_reg == ST_PRESENT && i_ack |=> o_stacked_vector == $past(o_vector))
		else $error("stacked vector differs from presented vector");

	a_addr_vec_x4: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ15]
		o_vector_addr == (`VIC_TABLE_BASE + {22'h0, o_vector, 2'b00}))
		else $error("table address not four times vector");

	a_periph_vec_map: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ6]
		i_clk_en && state_reg == ST_IDLE && any_next && !nmi_reg && i_core_exc == '0
		|=> o_vector == `VIC_PERIPH_BASE + {3'h0, $past(arb_line)})
		else $error("peripheral vector is not line plus sixteen");

	a_nmi_vector_two: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ8]
		i_clk_en && state_reg == ST_IDLE && nmi_reg |=> o_vector == `VIC_VEC_NMI ##0 o_req)
		else $error("nmi not presented at vector two");

	a_level_is_best: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ1]
		arb_found |-> fields[arb_line] == arb_level && o_pending[arb_line])
		else $error("winning line level or pending mismatch");

	a_field_position: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ18]
		fields[`VIC_LINE_SPI0] == i_priority_registers[2][23:22])
		else $error("priority field of line ten misplaced");

	a_line4_silent: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ10]
		!o_pending[4] && !o_pending[23] && !o_pending[29])
		else $error("unassigned line shows pending");

	a_req_holds_ack: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		o_req && !i_ack |=> o_req && $stable(o_vector))
		else $error("request dropped or vector moved before ack");

	// a low enable must leave capture and delivery exactly where they were
	a_clk_en_freeze: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!i_clk_en |=> $stable(o_req) && $stable(o_vector) && $stable(o_pending)
			&& $stable(o_stacked_vector) && $stable(state_reg))
		else $error("state moved while clock enable low");

	// no pending line may be more urgent than the winner; a tie goes to the lower line
	for (genvar c = 0; c < `VIC_NUM_LINES; c++) begin : g_arb_check
		a_winner_most_urgent: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ1]
			arb_found && o_pending[c]
			|-> fields[c] > arb_level || (fields[c] == arb_level && c >= {27'h0, arb_line}))
			else $error("a more urgent pending line lost arbitration");
	end

	a_found_if_pending: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ1]
		|o_pending |-> arb_found)
		else $error("pending line found no winner");

	a_stacked_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ5]
		!(i_clk_en && o_req && i_ack) |=> $stable(o_stacked_vector))
		else $error("stacked vector changed without acknowledge");

	a_ack_drops_req: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && o_req && i_ack |=> !o_req)
		else $error("request stayed up after acknowledge");

	a_hard_fault_vec: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ8]
		i_clk_en && state_reg == ST_IDLE && !nmi_reg && i_core_exc.hard_fault |=> o_vector == `VIC_VEC_HARD_FAULT)
		else $error("hard fault not presented at vector three");

	a_no_reserved_vec: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ8]
		o_vector != 8'h01 && !(o_vector >= 8'h04 && o_vector <= 8'h0A) && o_vector != 8'h0C && o_vector != 8'h0D)
		else $error("reserved core vector presented");

	a_return_to_idle: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		i_clk_en && state_reg == ST_ACTIVE && i_exc_return |=> state_reg == ST_IDLE && !o_req)
		else $error("service end did not return to idle");

	a_state_onehot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		$onehot(state_reg))
		else $error("delivery state not one-hot");

	a_pending_follows: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [RQ17]
		i_clk_en |=> o_pending == $past(lines & i_line_enable))
		else $error("pending does not follow enabled lines");

endmodule : vectored_interrupt_controller

/* File: dv/vic_core_model.sv */
// core-side model: takes each presented vector after a set wait, then ends service.
// assumes: same clock and synchronous reset as the controller.
module vic_core_model (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_req,
	input wire logic [3:0] i_wait,
	output logic o_ack,
	output logic o_exc_return
);
	timeunit 1ns;
	timeprecision 100ps;
	logic busy_reg;
	logic [3:0] cnt_reg;

	// ack held until taken with the request; return pulse four cycles later
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			busy_reg <= 1'b0;
			cnt_reg <= 4'h0;
			o_ack <= 1'b0;
			o_exc_return <= 1'b0;
		end else begin
			o_exc_return <= 1'b0;
			if (o_ack && i_req) begin
				o_ack <= 1'b0;
				busy_reg <= 1'b1;
				cnt_reg <= 4'h0;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg + 4'h1;
				if (cnt_reg == 4'h3) begin
					o_exc_return <= 1'b1;
					busy_reg <= 1'b0;
					cnt_reg <= 4'h0;
				end
			end else if (i_req && !o_ack) begin
				// slow answers stretch the presented phase
				if (cnt_reg == i_wait) begin
					o_ack <= 1'b1;
					cnt_reg <= 4'h0;
				end else begin
					cnt_reg <= cnt_reg + 4'h1;
				end
			end
		end
	end
endmodule : vic_core_model

/* File: dv/vectored_interrupt_controller_tb.sv */
// testbench for the controller: line map, priority fields, core vectors.
// assumes: vic_pkg compiled first; core side answered by vic_core_model.
`define CHK(nm, got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_errors++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module vectored_interrupt_controller_tb
	import vic_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_clk_en = 1'b1;
	periph_src_s i_src = '0;
	core_exc_s i_core_exc = '0;
	logic i_nmi_pin_n = 1'b1;
	logic i_nmi_pin_sel = 1'b0;
	logic [31:0] i_line_enable = '1;
	prio_regs_t i_priority_registers = {8{32'h3F3F3F3F}};
	logic i_ack, i_exc_return, o_req;
	logic [7:0] o_vector, o_stacked_vector;
	logic [31:0] o_vector_addr, o_pending;
	logic [1:0] o_level;
	logic [3:0] ack_wait = 4'h0;
	int n_errors = 0;
	int samples_checked = 0;
	// line reached by each source bit, lowest struct bit first
	byte unsigned line_of [0:28] = '{31, 30, 28, 27, 22, 22, 21, 20, 17, 18, 19, 16, 15, 12, 13, 14, 10, 11,
		8, 9, 7, 6, 6, 5, 5, 0, 1, 2, 3};

	always #10 i_clk = ~i_clk;

	vectored_interrupt_controller i_vectored_interrupt_controller (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_clk_en(i_clk_en), .i_src(i_src), .i_core_exc(i_core_exc), .i_nmi_pin_n(i_nmi_pin_n),
		.i_nmi_pin_sel(i_nmi_pin_sel), .i_line_enable(i_line_enable), .i_priority_registers(i_priority_registers),
		.i_ack(i_ack), .i_exc_return(i_exc_return), .o_req(o_req), .o_vector(o_vector),
		.o_vector_addr(o_vector_addr), .o_stacked_vector(o_stacked_vector), .o_level(o_level), .o_pending(o_pending));
	vic_core_model i_vic_core_model (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(o_req), .i_wait(ack_wait),
		.o_ack(i_ack), .o_exc_return(i_exc_return));

	task automatic complete_run();
		$display("errors %0d, checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run

	// waits for a vector, checks it, lets the core take it, then clears all sources
	task automatic serve(input logic [7:0] v, input logic chk_lv, input logic [1:0] lv);
		int k;
		for (k = 0; k < 40 && o_req !== 1'b1; k++) @(negedge i_clk);
		`CHK("request", o_req, 1'b1)
		`CHK("vector", o_vector, v)
		`CHK("address", o_vector_addr, {22'h0, v, 2'h0})
		if (chk_lv) `CHK("level", o_level, lv)
		for (k = 0; k < 40 && !(o_req === 1'b1 && i_ack === 1'b1); k++) @(negedge i_clk);
		@(negedge i_clk);
		`CHK("stacked", o_stacked_vector, v)
		@(posedge i_clk);
		i_src <= '0;
		i_core_exc <= '0;
		i_nmi_pin_n <= 1'b1;
		repeat (10) @(negedge i_clk);
	endtask : serve

	task automatic quiet(input int n);
		repeat (n) begin
			@(negedge i_clk);
			`CHK("no request", o_req, 1'b0)
		end
	endtask : quiet

	// field position from register index and byte offset
	function automatic prio_regs_t put(prio_regs_t p, int line, logic [1:0] lv);
		p[line / 4][8 * (line % 4) + 6 +: 2] = lv;
		return p;
	endfunction : put

	task automatic apply(prio_regs_t p, periph_src_s s, logic [31:0] en, logic [7:0] v, logic [1:0] lv);
		@(posedge i_clk);
		i_priority_registers <= p;
		i_src <= s;
		i_line_enable <= en;
		serve(v, 1'b1, lv);
	endtask : apply

	// every source alone, then all at once for the pending mask
	task automatic t_map();
		periph_src_s s;
		logic [31:0] m;
		m = '0;
		for (int b = 0; b < 29; b++) begin
			s = '0;
			s[b] = 1'b1;
			m[line_of[b]] = 1'b1;
			@(posedge i_clk);
			i_src <= s;
			serve(8'h10 + line_of[b], 1'b1, 2'h0);
		end
		@(posedge i_clk);
		i_src <= '1;
		repeat (2) @(negedge i_clk);
		`CHK("pending", o_pending, m)
		serve(8'h10, 1'b1, 2'h0);
	endtask : t_map

	// low six bits of every byte are set, so a misplaced field shows
	task automatic t_prio();
		periph_src_s a;
		periph_src_s b;
		prio_regs_t p;
		a = '0;
		a.spi[0] = 1'b1;
		a.uart[0] = 1'b1;
		b = '0;
		b.dma_done_err[0] = 1'b1;
		b.port_d_detect = 1'b1;
		p = {8{32'h3F3F3F3F}};
		@(posedge i_clk);
		ack_wait <= 4'h5;
		apply(put(put(p, 10, 2'h3), 12, 2'h1), a, '1, 8'h1C, 2'h1);
		apply(put(put(p, 10, 2'h0), 12, 2'h1), a, '1, 8'h1A, 2'h0);
		apply(put(put(p, 10, 2'h2), 12, 2'h2), a, '1, 8'h1A, 2'h2);
		apply(put(put(p, 0, 2'h3), 31, 2'h2), b, '1, 8'h2F, 2'h2);
		apply(put(put(p, 0, 2'h3), 31, 2'h2), b, 32'h7FFFFFFF, 8'h10, 2'h3);
	endtask : t_prio

	task automatic t_core();
		logic [7:0] vec [0:3] = '{8'h03, 8'h0B, 8'h0E, 8'h0F};
		for (int i = 0; i < 4; i++) begin
			@(posedge i_clk);
			i_core_exc <= core_exc_s'(4'h8 >> i);
			serve(vec[i], 1'b0, 2'h0);
		end
		@(posedge i_clk);
		i_nmi_pin_n <= 1'b0;
		quiet(8);
		@(posedge i_clk);
		i_nmi_pin_sel <= 1'b1;
		serve(8'h02, 1'b0, 2'h0);
	endtask : t_core

	// clock enable low freezes capture and delivery; both resume once it returns
	task automatic t_hold();
		periph_src_s s;
		s = '0;
		s.spi[1] = 1'b1;
		@(posedge i_clk);
		i_clk_en <= 1'b0;
		i_src <= s;
		repeat (4) @(negedge i_clk);
		`CHK("held pending", o_pending, 32'h0)
		`CHK("held request", o_req, 1'b0)
		@(posedge i_clk);
		i_clk_en <= 1'b1;
		serve(8'h1B, 1'b1, 2'h0);
	endtask : t_hold

	initial begin
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		t_map();
		t_prio();
		t_core();
		t_hold();
		complete_run();
	end

	// watchdog, well past the seven hundred or so cycles the tests need
	initial begin
		repeat (5000) @(posedge i_clk);
		n_errors++;
		complete_run();
	end
endmodule : vectored_interrupt_controller_tb
